// ==== hw/pmc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the power mode controller.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// Register byte offsets.
`define PMC_CTRL_OFF       8'h00
`define PMC_STATUS_OFF     8'h04
`define PMC_RESET_CAUSE_OFF 8'h08
`define PMC_WAKE_CFG_OFF   8'h0C
`define PMC_RTC_CNT_OFF    8'h10
`define PMC_RTC_CMP0_OFF   8'h14
`define PMC_RTC_CMP1_OFF   8'h18
`define PMC_RTC_CMP2_OFF   8'h1C
`define PMC_RTC_CAPT_OFF   8'h20
`define PMC_IO_LATCH_OFF   8'h24

// Control register fields.
`define PMC_CTRL_MODE_LSB  0
`define PMC_CTRL_LS_SEL    2
`define PMC_CTRL_CLKOUT    3
`define PMC_CTRL_RTC_EN    4
`define PMC_CTRL_RESET     32'h0000_0000

// Reset cause codes.
`define PMC_CAUSE_POR      2'h0
`define PMC_CAUSE_PIN      2'h1
`define PMC_CAUSE_SHDN     2'h2

// Wake times in nanoseconds and the idle cycle count at 25 ns.
`define PMC_CLK_NS         25
`define PMC_WAKE_IDLE_NS   14000
`define PMC_WAKE_STBY_NS   151000
`define PMC_WAKE_SHDN_NS   1015000
`define PMC_WAKE_IDLE_CYC  (`PMC_WAKE_IDLE_NS / `PMC_CLK_NS)

// Brownout duty cycle in standby: on for one cycle out of this many.
`define PMC_BOD_DUTY       16

`endif

// ==== hw/pmc_pkg.sv ====
// Types shared by the power mode controller.
// Assumes the register header is compiled alongside.
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_MODE_ACTIVE,
    PMC_MODE_IDLE,
    PMC_MODE_STANDBY,
    PMC_MODE_SHUTDOWN
  } pmc_mode_t;
endpackage

// ==== hw/pmc_power_mode_controller.sv ====
// Power mode controller: mode sequencing, domain gating, wake sources, I/O latch, RTC, reset cause.
// Assumes one 40 MHz clock, AXI4-Lite software access, and pins synchronised here.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"

module pmc_power_mode_controller #(
  parameter int NUM_IO          = 16,
  parameter int WAKE_STBY_CYC   = `PMC_WAKE_STBY_NS / `PMC_CLK_NS,
  parameter int WAKE_SHDN_CYC   = `PMC_WAKE_SHDN_NS / `PMC_CLK_NS
) (
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Processor side.
  input  wire logic                  cpu_sleep,
  input  wire logic                  irq_event,
  output pmc_pkg::pmc_mode_t         power_mode,
  output logic                       cpu_reset_n,
  // Domain gating.
  output logic                       cpu_clk_en,
  output logic                       mem_clk_en,
  output logic                       flash_pwr,
  output logic                       sram_pwr,
  output logic                       radio_pwr,
  output logic                       periph_clk_en,
  output logic                       hs_crystal_osc_en,
  output logic                       hs_doubler_en,
  output logic                       always_on_domain_en,
  output logic                       supply_duty,
  output logic                       brownout_detector_en,
  output logic                       por_monitor_en,
  output logic                       sensor_engine_en,
  // Low-speed clock sources and routing.
  input  wire logic                  ls_crystal_osc,
  input  wire logic                  ls_rc_osc,
  output logic                       ls_crystal_osc_en,
  output logic                       ls_rc_osc_en,
  output logic                       ls_clk_out,
  output logic                       ls_clk_out_en,
  // Wake sources and RTC capture.
  input  wire logic                  reset_pin_n,
  input  wire logic                  sensor_wake,
  input  wire logic                  rtc_capture_in,
  // General-purpose pins.
  input  wire logic [NUM_IO-1:0]     io_in,
  input  wire logic [NUM_IO-1:0]     io_out_core,
  output logic [NUM_IO-1:0]          io_out,
  output logic                       io_hold
);
  import pmc_pkg::*;

  initial begin
    if (NUM_IO < 1 || NUM_IO > 30 || WAKE_STBY_CYC < 1 || WAKE_SHDN_CYC < 1) begin
      $error("pmc_power_mode_controller: unsupported parameter value");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins and asynchronous sources.

  localparam int NSYNC = NUM_IO + 5;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire  [NSYNC-1:0] sync_in = {io_in, reset_pin_n, sensor_wake, rtc_capture_in,
                               ls_crystal_osc, ls_rc_osc};

  always_ff @(posedge aclk) begin
    sync_a <= sync_in;
    sync_b <= sync_a;
  end

  wire [NUM_IO-1:0] io_s   = sync_b[NSYNC-1:5];
  wire              rst_pin_s = sync_b[4];
  wire              sens_s = sync_b[3];
  wire              capt_s = sync_b[2];
  wire              lsx_s  = sync_b[1];
  wire              lsr_s  = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0]        ctrl;
  logic [1:0]         reset_cause;
  logic [NUM_IO-1:0]  wake_pin_mask;
  logic [NUM_IO-1:0]  io_latch;
  logic               sensor_wake_en;
  logic               rtc_wake_en;
  logic [31:0]        rtc_cnt;
  logic [31:0]        rtc_cmp [3];
  logic [31:0]        rtc_capt;
  logic               por_done;

  pmc_mode_t          mode;
  pmc_mode_t          target;
  logic               waking;
  logic [31:0]        wake_cnt;
  logic               shdn_reset;
  logic [3:0]         bod_cnt;
  logic [NUM_IO-1:0]  io_prev;
  logic               lsclk_prev;
  logic               capt_prev;
  logic               rst_pin_prev;

  wire pmc_mode_t req_mode = pmc_mode_t'(ctrl[`PMC_CTRL_MODE_LSB +: 2]);
  wire ls_sel     = ctrl[`PMC_CTRL_LS_SEL];
  wire lsclk_s    = ls_sel ? lsx_s : lsr_s;
  wire rtc_tick   = lsclk_s & ~lsclk_prev;
  wire rtc_run    = ctrl[`PMC_CTRL_RTC_EN] & (mode != PMC_MODE_SHUTDOWN);

  ////////////////////////////////////////////////////////////////////////////////
  // Wake decoding.

  logic [2:0] cmp_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      assign cmp_hit[gi] = rtc_run & rtc_tick & (rtc_cnt == rtc_cmp[gi]);
    end
  endgenerate

  wire rtc_wake     = rtc_wake_en & (|cmp_hit);
  wire pin_edge     = |((io_s ^ io_prev) & wake_pin_mask);
  wire sens_ev      = sensor_wake_en & sens_s;
  wire stby_wake    = pin_edge | rtc_wake | sens_ev;
  wire reset_pin_ev = ~rst_pin_s;
  wire reset_rel    = rst_pin_s & ~rst_pin_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode sequencer.

  always_ff @(posedge aclk) begin
    io_prev      <= io_s;
    lsclk_prev   <= lsclk_s;
    capt_prev    <= capt_s;
    rst_pin_prev <= rst_pin_s;
    if (!aresetn) begin
      mode       <= PMC_MODE_ACTIVE;
      target     <= PMC_MODE_ACTIVE;
      waking     <= 1'b1;
      wake_cnt   <= WAKE_SHDN_CYC;
      shdn_reset <= 1'b0;
      bod_cnt    <= 4'h0;
    end else begin
      bod_cnt <= bod_cnt + 4'h1;
      if (reset_pin_ev) begin
        mode     <= PMC_MODE_ACTIVE;
        waking   <= 1'b1;
        wake_cnt <= WAKE_SHDN_CYC;
      end else if (waking) begin
        if (wake_cnt <= 32'd1) begin
          waking     <= 1'b0;
          shdn_reset <= 1'b0;
        end else begin
          wake_cnt <= wake_cnt - 32'd1;
        end
      end else begin
        case (mode)
          PMC_MODE_ACTIVE: begin
            if (cpu_sleep && req_mode != PMC_MODE_ACTIVE) begin
              mode <= req_mode;
            end
          end
          PMC_MODE_IDLE: begin
            if (irq_event) begin
              mode     <= PMC_MODE_ACTIVE;
              waking   <= 1'b1;
              wake_cnt <= `PMC_WAKE_IDLE_CYC;
            end
          end
          PMC_MODE_STANDBY: begin
            if (stby_wake) begin
              mode     <= PMC_MODE_ACTIVE;
              waking   <= 1'b1;
              wake_cnt <= WAKE_STBY_CYC;
            end
          end
          PMC_MODE_SHUTDOWN: begin
            if (pin_edge) begin
              mode       <= PMC_MODE_ACTIVE;
              waking     <= 1'b1;
              wake_cnt   <= WAKE_SHDN_CYC;
              shdn_reset <= 1'b1;
            end
          end
          default: mode <= PMC_MODE_ACTIVE;
        endcase
      end
    end
  end

  // Reset cause is loaded with POR under reset and captured again after the power-on release.
  wire clear_regs = !aresetn || reset_pin_ev || (shdn_reset && waking);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_done    <= 1'b0;
      reset_cause <= `PMC_CAUSE_POR;
    end else begin
      por_done <= 1'b1;
      if (reset_pin_ev) begin
        reset_cause <= `PMC_CAUSE_PIN;
      end else if (mode == PMC_MODE_SHUTDOWN && pin_edge) begin
        reset_cause <= `PMC_CAUSE_SHDN;
      end else if (!por_done) begin
        reset_cause <= `PMC_CAUSE_POR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Domain gating and clocks.

  wire m_act  = (mode == PMC_MODE_ACTIVE);
  wire m_idle = (mode == PMC_MODE_IDLE);
  wire m_stby = (mode == PMC_MODE_STANDBY);
  wire m_on   = m_act | m_idle;
  wire held   = reset_pin_ev;

  assign cpu_clk_en           = m_act & ~waking & ~held;
  assign mem_clk_en           = m_act & ~held;
  assign flash_pwr            = m_on & ~held;
  assign sram_pwr             = (m_on | m_stby) & ~held;
  assign radio_pwr            = m_on & ~held;
  assign periph_clk_en        = m_on & ~held;
  assign hs_crystal_osc_en    = m_on & ~held;
  assign hs_doubler_en        = hs_crystal_osc_en;
  assign always_on_domain_en  = (mode != PMC_MODE_SHUTDOWN) & ~held;
  assign supply_duty          = m_stby;
  assign brownout_detector_en = ~held & (m_on | (m_stby & (bod_cnt == 4'h0)));
  assign por_monitor_en       = 1'b1;
  assign sensor_engine_en     = always_on_domain_en;
  assign ls_crystal_osc_en    = always_on_domain_en & ls_sel;
  assign ls_rc_osc_en         = always_on_domain_en & ~ls_sel;
  assign ls_clk_out           = lsclk_s & ctrl[`PMC_CTRL_CLKOUT];
  assign ls_clk_out_en        = ctrl[`PMC_CTRL_CLKOUT] & always_on_domain_en;
  assign cpu_reset_n          = ~held & ~(shdn_reset & waking);
  assign power_mode           = mode;

  // Pins freeze at the latched value in standby and shutdown.
  wire hold = m_stby | (mode == PMC_MODE_SHUTDOWN);
  assign io_hold = hold;
  assign io_out  = hold ? io_latch : io_out_core;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire   wr_go = aw_got & w_got & ~s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  wire wr_known = aw_addr inside {`PMC_CTRL_OFF, `PMC_WAKE_CFG_OFF, `PMC_RTC_CNT_OFF,
                   `PMC_RTC_CMP0_OFF, `PMC_RTC_CMP1_OFF, `PMC_RTC_CMP2_OFF};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file; lost on any reset source, so a shutdown wake restarts it cleanly.
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      ctrl           <= `PMC_CTRL_RESET;
      wake_pin_mask  <= '0;
      sensor_wake_en <= 1'b0;
      rtc_wake_en    <= 1'b0;
      rtc_cnt        <= 32'h0000_0000;
      rtc_capt       <= 32'h0000_0000;
      for (int i = 0; i < 3; i++) begin
        rtc_cmp[i] <= 32'hFFFF_FFFF;
      end
    end else begin
      if (rtc_run && rtc_tick) begin
        rtc_cnt <= rtc_cnt + 32'h1;
      end
      if (rtc_run && capt_s && !capt_prev) begin
        rtc_capt <= rtc_cnt;
      end
      if (cpu_sleep && m_act && !waking) begin
        ctrl[1:0] <= 2'h0;
      end
      if (wr_go) begin
        case (aw_addr)
          `PMC_CTRL_OFF:     ctrl <= merge(ctrl, w_data, w_strb);
          `PMC_WAKE_CFG_OFF: begin
            wake_pin_mask  <= NUM_IO'(merge(32'(wake_pin_mask), w_data, w_strb));
            sensor_wake_en <= w_strb[3] ? w_data[31] : sensor_wake_en;
            rtc_wake_en    <= w_strb[3] ? w_data[30] : rtc_wake_en;
          end
          `PMC_RTC_CNT_OFF:  rtc_cnt <= merge(rtc_cnt, w_data, w_strb);
          `PMC_RTC_CMP0_OFF: rtc_cmp[0] <= merge(rtc_cmp[0], w_data, w_strb);
          `PMC_RTC_CMP1_OFF: rtc_cmp[1] <= merge(rtc_cmp[1], w_data, w_strb);
          `PMC_RTC_CMP2_OFF: rtc_cmp[2] <= merge(rtc_cmp[2], w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  // Pin latch survives shutdown: it follows the core only while outputs are live.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_latch <= '0;
    end else if (!hold) begin
      io_latch <= io_out_core;
    end
  end

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `PMC_CTRL_OFF:        rd_val = ctrl;
      `PMC_STATUS_OFF:      rd_val = {28'h0, 1'b0, waking, mode};
      `PMC_RESET_CAUSE_OFF: rd_val = {30'h0, reset_cause};
      `PMC_WAKE_CFG_OFF:    rd_val = {sensor_wake_en, rtc_wake_en, 30'(wake_pin_mask)};
      `PMC_RTC_CNT_OFF:     rd_val = rtc_cnt;
      `PMC_RTC_CMP0_OFF:    rd_val = rtc_cmp[0];
      `PMC_RTC_CMP1_OFF:    rd_val = rtc_cmp[1];
      `PMC_RTC_CMP2_OFF:    rd_val = rtc_cmp[2];
      `PMC_RTC_CAPT_OFF:    rd_val = rtc_capt;
      `PMC_IO_LATCH_OFF:    rd_val = 32'(io_latch);
      default:              rd_val = 32'h0000_0000;
    endcase
  end
  wire rd_known = s_axi_araddr <= `PMC_IO_LATCH_OFF && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pmc_power_mode_controller_assertions.sv ====
// Checker for the power mode controller: mode gating, wake timing and sleep entry.
// Assumes it is bound to the controller top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller_assertions #(
  parameter int NUM_IO = 16
) (
  // Clock and reset.
  input wire logic              aclk,
  input wire logic              aresetn,
  // Watched ports.
  input wire logic              cpu_sleep,
  input wire logic              irq_event,
  input wire logic              reset_pin_n,
  input wire pmc_pkg::pmc_mode_t power_mode,
  input wire logic              cpu_reset_n,
  input wire logic              cpu_clk_en,
  input wire logic              mem_clk_en,
  input wire logic              flash_pwr,
  input wire logic              sram_pwr,
  input wire logic              radio_pwr,
  input wire logic              periph_clk_en,
  input wire logic              hs_crystal_osc_en,
  input wire logic              always_on_domain_en,
  input wire logic              brownout_detector_en,
  input wire logic              por_monitor_en,
  input wire logic              sensor_engine_en,
  input wire logic [NUM_IO-1:0] io_out,
  input wire logic              io_hold
);
  import pmc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  AST_IDLE_GATE: assert property (
    power_mode == PMC_MODE_IDLE && cpu_reset_n |-> !cpu_clk_en && !mem_clk_en && periph_clk_en)
    else $error("idle gating wrong");
  AST_STBY_GATE: assert property (
    power_mode == PMC_MODE_STANDBY && cpu_reset_n |-> !flash_pwr && !radio_pwr && !periph_clk_en
      && !hs_crystal_osc_en && sram_pwr && always_on_domain_en)
    else $error("standby gating wrong");
  AST_STBY_HOLD: assert property (
    power_mode == PMC_MODE_STANDBY && $past(power_mode) == PMC_MODE_STANDBY
      |-> io_hold && $stable(io_out))
    else $error("pins moved in standby");
  AST_SHDN_GATE: assert property (
    power_mode == PMC_MODE_SHUTDOWN |-> !always_on_domain_en && !sensor_engine_en
      && !sram_pwr && !brownout_detector_en && io_hold)
    else $error("shutdown gating wrong");
  AST_BOD_RUN: assert property (
    power_mode inside {PMC_MODE_ACTIVE, PMC_MODE_IDLE} && cpu_reset_n
      |-> brownout_detector_en && por_monitor_en)
    else $error("brownout off while running");
  AST_IRQ_WAKE: assert property (
    power_mode == PMC_MODE_IDLE && irq_event |=> power_mode == PMC_MODE_ACTIVE)
    else $error("interrupt did not wake idle");
  AST_SLEEP_ONLY: assert property (
    power_mode == PMC_MODE_ACTIVE && !cpu_sleep |=> power_mode == PMC_MODE_ACTIVE)
    else $error("left active without sleep");
  AST_IDLE_TIME: assert property (
    power_mode == PMC_MODE_IDLE && irq_event |=> (!cpu_clk_en) [*8] ##[549:555] cpu_clk_en)
    else $error("idle wake time wrong");
  AST_PIN_RESET: assert property (
    (!reset_pin_n) [*5] |-> power_mode == PMC_MODE_ACTIVE && !cpu_reset_n)
    else $error("reset pin not honoured");
endmodule
bind pmc_power_mode_controller pmc_power_mode_controller_assertions #(.NUM_IO(NUM_IO)) u_chk (
  .aclk, .aresetn, .cpu_sleep, .irq_event, .reset_pin_n, .power_mode, .cpu_reset_n,
  .cpu_clk_en, .mem_clk_en, .flash_pwr, .sram_pwr, .radio_pwr, .periph_clk_en,
  .hs_crystal_osc_en, .always_on_domain_en, .brownout_detector_en, .por_monitor_en,
  .sensor_engine_en, .io_out, .io_hold
);
`default_nettype wire

// ==== testbench/pmc_cpu_model.sv ====
// Processor and wake-source model on the far side of the power mode controller.
// Assumes the controller's clock; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model (
  // Clock and mode.
  input wire logic               aclk,
  input wire pmc_pkg::pmc_mode_t power_mode,
  // Requests and wakes.
  output logic                   cpu_sleep,
  output logic                   irq_event,
  output logic                   sensor_wake,
  // Low-speed oscillators.
  output logic                   ls_crystal_osc,
  output logic                   ls_rc_osc
);
  import pmc_pkg::*;
  logic [3:0] div = 4'h0;
  initial begin
    cpu_sleep = 1'b0;
    irq_event = 1'b0;
    sensor_wake = 1'b0;
  end
  // Both oscillators run freely, far slower than the bus clock.
  always @(posedge aclk) begin
    div <= div + 4'h1;
  end
  assign ls_rc_osc = div[2];
  assign ls_crystal_osc = div[3];
  // Sleep is held until the mode leaves active or 20 cycles pass, so a slow controller is not missed.
  task sleep_req();
    int n;
    @(posedge aclk);
    n = 0;
    cpu_sleep <= 1'b1;
    while (power_mode == PMC_MODE_ACTIVE && n < 20) begin
      @(posedge aclk);
      n++;
    end
    cpu_sleep <= 1'b0;
  endtask
  task pulse(input logic sensor);
    @(posedge aclk);
    irq_event <= !sensor;
    sensor_wake <= sensor;
    @(posedge aclk);
    irq_event <= 1'b0;
    sensor_wake <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/pmc_power_mode_controller_test.sv ====
// Self-checking bench for the power mode controller.
// Assumes the processor model drives sleep and wake lines; standby and shutdown wake counts are shortened.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module pmc_power_mode_controller_test;
  import pmc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, reset_pin_n = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_sleep, irq_event, sensor_wake, ls_crystal_osc, ls_rc_osc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic cpu_reset_n, cpu_clk_en, mem_clk_en, flash_pwr, sram_pwr, radio_pwr, periph_clk_en;
  logic hs_doubler_en, always_on_domain_en, sensor_engine_en, ls_clk_out_en, io_hold;
  logic hs_crystal_osc_en, supply_duty, brownout_detector_en, por_monitor_en, ls_clk_out;
  logic ls_crystal_osc_en, ls_rc_osc_en;
  logic [15:0] io_in = 16'h0000, io_out_core = 16'h0000, io_out;
  pmc_mode_t power_mode;
  int err_count = 0, checked = 0;
  always #12.5 aclk = ~aclk;
  pmc_cpu_model u_cpu (.aclk, .power_mode, .cpu_sleep, .irq_event, .sensor_wake,
    .ls_crystal_osc, .ls_rc_osc);
  pmc_power_mode_controller #(.NUM_IO(16), .WAKE_STBY_CYC(20), .WAKE_SHDN_CYC(40)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cpu_sleep, .irq_event, .power_mode, .cpu_reset_n, .cpu_clk_en,
    .mem_clk_en, .flash_pwr, .sram_pwr, .radio_pwr, .periph_clk_en, .hs_crystal_osc_en,
    .hs_doubler_en, .always_on_domain_en, .supply_duty, .brownout_detector_en,
    .por_monitor_en, .sensor_engine_en, .ls_crystal_osc, .ls_rc_osc,
    .ls_crystal_osc_en, .ls_rc_osc_en, .ls_clk_out, .ls_clk_out_en, .reset_pin_n,
    .sensor_wake, .rtc_capture_in(1'b0), .io_in, .io_out_core, .io_out, .io_hold);
  ////////////////////////////////////////////////////////////
  task stop_test();
    $display("counts: %0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 50) begin
      err_count++;
      $display("ERROR bus answer expected 1 seen 0");
      stop_test();
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n);
    `CHK("bresp", 2'h0, s_axi_bresp)
  endtask
  task axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    tmo(n);
  endtask
  // Waits for the processor clock (run) or for mode m; a hang ends the run.
  task wait_for(input logic run, input pmc_mode_t m, output int n);
    n = 0;
    while (!(run ? cpu_clk_en === 1'b1 : power_mode === m) && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 1000) begin
      err_count++;
      $display("ERROR wait expected %h seen %h", m, power_mode);
      stop_test();
    end
  endtask
  task t_reset();
    int n;
    logic [4:0] k;
    wait_for(1'b1, PMC_MODE_ACTIVE, n);
    `CHK("boot wake", 1'b1, n >= 38 && n <= 42)
    axr(`PMC_RESET_CAUSE_OFF); `CHK("cause", 32'h0, rd)
    axr(`PMC_RTC_CMP0_OFF); `CHK("cmp0", 32'hFFFF_FFFF, rd)
    axr(8'h40); `CHK("unmapped", 34'h2_0000_0000, {rs, rd})
    `CHK("hs clock", 3'h7, {hs_crystal_osc_en, brownout_detector_en, por_monitor_en})
    `CHK("ls clock", 3'h4, {ls_rc_osc_en, ls_crystal_osc_en, supply_duty})
    `CHK("active", 6'h3F, {cpu_clk_en, mem_clk_en, flash_pwr, sram_pwr, periph_clk_en, hs_doubler_en})
    axw(`PMC_CTRL_OFF, 32'h8); `CHK("clk out", 1'b1, ls_clk_out_en)
    k = 5'h00;
    repeat (16) begin
      @(posedge aclk);
      k = k + {4'h0, ls_clk_out};
    end
    `CHK("clk out level", 5'h08, k)
    $display("reset test done");
  endtask
  task t_idle();
    int n;
    axw(`PMC_CTRL_OFF, 32'h1);
    u_cpu.sleep_req();
    wait_for(1'b0, PMC_MODE_IDLE, n);
    `CHK("idle", 3'b001, {cpu_clk_en, mem_clk_en, periph_clk_en})
    u_cpu.pulse(1'b0);
    wait_for(1'b0, PMC_MODE_ACTIVE, n);
    wait_for(1'b1, PMC_MODE_ACTIVE, n);
    `CHK("idle wake", 1'b1, n >= 555 && n <= 565)
    $display("idle test done");
  endtask
  task t_standby();
    int n;
    logic [4:0] k;
    io_out_core <= 16'hA5A5;
    axw(`PMC_WAKE_CFG_OFF, 32'h8000_0000);
    axw(`PMC_CTRL_OFF, 32'h2);
    u_cpu.sleep_req();
    wait_for(1'b0, PMC_MODE_STANDBY, n);
    io_out_core <= 16'h5A5A;
    `CHK("stby", 7'h07, {flash_pwr, radio_pwr, periph_clk_en, cpu_clk_en, sram_pwr, always_on_domain_en, sensor_engine_en})
    `CHK("stby duty", 1'b1, supply_duty)
    k = 5'h00;
    repeat (16) begin
      @(posedge aclk);
      k = k + {4'h0, brownout_detector_en};
    end
    `CHK("bod duty", 5'h01, k)
    u_cpu.pulse(1'b0);
    @(posedge aclk);
    `CHK("stby irq", PMC_MODE_STANDBY, power_mode)
    `CHK("stby pins", 17'h1A5A5, {io_hold, io_out})
    u_cpu.pulse(1'b1);
    wait_for(1'b0, PMC_MODE_ACTIVE, n);
    wait_for(1'b1, PMC_MODE_ACTIVE, n);
    `CHK("stby wake", 1'b1, n >= 18 && n <= 22)
    axr(`PMC_WAKE_CFG_OFF); `CHK("retained", 32'h8000_0000, rd)
    $display("standby test done");
  endtask
  task t_shutdown();
    int n;
    axw(`PMC_WAKE_CFG_OFF, 32'h1);
    axw(`PMC_CTRL_OFF, 32'h3);
    u_cpu.sleep_req();
    wait_for(1'b0, PMC_MODE_SHUTDOWN, n);
    io_out_core <= 16'h0F0F;
    @(posedge aclk);
    `CHK("shdn", 21'h15A5A, {always_on_domain_en, sensor_engine_en, sram_pwr, flash_pwr, io_hold, io_out})
    io_in <= 16'h0001;
    wait_for(1'b0, PMC_MODE_ACTIVE, n);
    wait_for(1'b1, PMC_MODE_ACTIVE, n);
    `CHK("shdn wake", 1'b1, n >= 38 && n <= 42)
    axr(`PMC_RESET_CAUSE_OFF); `CHK("cause", 32'h2, rd)
    axr(`PMC_WAKE_CFG_OFF); `CHK("lost", 32'h0, rd)
    $display("shutdown test done");
  endtask
  task t_pin();
    int n;
    axw(`PMC_CTRL_OFF, 32'h1);
    u_cpu.sleep_req();
    wait_for(1'b0, PMC_MODE_IDLE, n);
    reset_pin_n <= 1'b0;
    wait_for(1'b0, PMC_MODE_ACTIVE, n);
    repeat (5) @(posedge aclk);
    `CHK("pin reset", 1'b0, cpu_reset_n)
    reset_pin_n <= 1'b1;
    wait_for(1'b1, PMC_MODE_ACTIVE, n);
    axr(`PMC_RESET_CAUSE_OFF); `CHK("cause", 32'h1, rd)
    $display("reset pin test done");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_idle();
    t_standby();
    t_shutdown();
    t_pin();
    stop_test();
  end
endmodule
`default_nettype wire
